// File: shared/fcbd_pkg.sv
package fcbd_pkg;
	// bus widths and default block geometry
	localparam int ADDR_W = 24;
	localparam int DATA_W = 16;
	localparam int BLOCK_SHIFT = 16;
	localparam int BUF_MAX = 32;
	// command codes, low data byte
	localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
	localparam logic [7:0] CMD_READ_IDENT = 8'h90;
	localparam logic [7:0] CMD_READ_QUERY = 8'h98;
	localparam logic [7:0] CMD_READ_STATUS = 8'h70;
	localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
	localparam logic [7:0] CMD_PROG_SETUP = 8'h40;
	localparam logic [7:0] CMD_PROG_SETUP_ALT = 8'h10;
	localparam logic [7:0] CMD_BUF_PROG = 8'hE8;
	localparam logic [7:0] CMD_CONFIRM = 8'hD0;
	localparam logic [7:0] CMD_FAST_FACTORY_BUFFER_PROGRAM_SETUP = 8'h80;
	localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
	localparam logic [7:0] CMD_SUSPEND = 8'hB0;
	localparam logic [7:0] CMD_LOCK_SETUP = 8'h60;
	localparam logic [7:0] CMD_LOCK = 8'h01;
	localparam logic [7:0] CMD_LOCKDOWN = 8'h2F;
	localparam logic [7:0] CMD_CFG = 8'h03;
	localparam logic [7:0] CMD_OTP_SETUP = 8'hC0;
	// status byte fields and reset value
	localparam int SR_READY = 7;
	localparam int SR_ERASE_SUSP = 6;
	localparam int SR_ERASE_ERR = 5;
	localparam int SR_PROG_ERR = 4;
	localparam int SR_PROG_SUSP = 2;
	localparam logic [7:0] SR_RESET = 8'h80;
	localparam logic [15:0] CFG_RESET = 16'h0000;
	// internal sequencer and host bus timing, in i_clk_sys cycles
	localparam int PROG_CYCLES = 64;
	localparam int ERASE_CYCLES = 256;
	localparam int TIMER_W = 16;
	localparam int HOST_WR_CYCLES = 2;
	localparam int HOST_RD_CYCLES = 4;
	localparam int HOST_GAP_CYCLES = 1;

	typedef enum logic [1:0] {
		RD_ARRAY = 2'b00,
		RD_IDENT = 2'b01,
		RD_QUERY = 2'b10,
		RD_STATUS = 2'b11
	} fcbd_mode_t;

	typedef enum logic [3:0] {
		OP_NONE = 4'b0000,
		OP_PROG = 4'b0001,
		OP_BUF = 4'b0010,
		OP_FAST_FACTORY_BUFFER_PROGRAM_WORD = 4'b0011,
		OP_ERASE = 4'b0100,
		OP_LOCK = 4'b0101,
		OP_UNLOCK = 4'b0110,
		OP_LOCKDOWN = 4'b0111,
		OP_OTP = 4'b1000,
		OP_CFG = 4'b1001
	} fcbd_op_t;
endpackage

// File: shared/fcbd_if.sv
`timescale 1ns/1ps
interface fcbd_if #(parameter int ADDR_W = 24, parameter int DATA_W = 16);
	logic rst_n;
	logic ce_n;
	logic we_n;
	logic oe_n;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] h_dq_out;
	logic h_dq_oe;
	logic [DATA_W-1:0] d_dq_out;
	logic d_dq_oe;
	logic [DATA_W-1:0] dq;

	// resolved data bus, pulled high when nobody drives
	assign dq = d_dq_oe ? d_dq_out : (h_dq_oe ? h_dq_out : {DATA_W{1'b1}});

	modport host (output rst_n, ce_n, we_n, oe_n, addr, h_dq_out, h_dq_oe, input dq);
	modport dev (input rst_n, ce_n, we_n, oe_n, addr, dq, output d_dq_out, d_dq_oe);
endinterface

// File: hw/fcbd_host.sv
`timescale 1ns/1ps
module fcbd_host #(
	parameter int WR_CYCLES = fcbd_pkg::HOST_WR_CYCLES,
	parameter int RD_CYCLES = fcbd_pkg::HOST_RD_CYCLES,
	parameter int GAP_CYCLES = fcbd_pkg::HOST_GAP_CYCLES
) (
	input wire logic i_clk_sys,
	input wire logic i_reset_n,
	input wire logic i_dev_reset,
	input wire logic i_cmd_valid,
	input wire logic i_cmd_write,
	input wire logic [fcbd_pkg::ADDR_W-1:0] i_cmd_addr,
	input wire logic [fcbd_pkg::DATA_W-1:0] i_cmd_data,
	output logic o_cmd_ready,
	output logic o_rd_valid,
	output logic [fcbd_pkg::DATA_W-1:0] o_rd_data,
	fcbd_if.host bus
);
	typedef enum logic [1:0] {
		H_IDLE = 2'b00,
		H_WRITE = 2'b01,
		H_READ = 2'b10,
		H_GAP = 2'b11
	} fcbd_hstate_t;

	typedef struct packed {
		fcbd_hstate_t st;
		logic [7:0] cnt;
		logic ce_n;
		logic we_n;
		logic oe_n;
		logic dq_oe;
		logic [fcbd_pkg::ADDR_W-1:0] addr;
		logic [fcbd_pkg::DATA_W-1:0] data;
		logic rd_valid;
		logic [fcbd_pkg::DATA_W-1:0] rd_data;
		logic dev_rst_n;
	} fcbd_hs_t;

	fcbd_hs_t s_reg;
	fcbd_hs_t s_next;

	// one bus cycle at a time: strobes low for a fixed count, then a gap
	always_comb begin
		s_next = s_reg;
		s_next.rd_valid = 1'b0;
		s_next.dev_rst_n = ~i_dev_reset;
		case (s_reg.st)
			H_IDLE: begin
				if (i_cmd_valid) begin
					// address held from the first cycle of every sequence
					s_next.addr = i_cmd_addr;
					s_next.data = i_cmd_data;
					s_next.ce_n = 1'b0;
					s_next.cnt = 8'h00;
					if (i_cmd_write) begin
						// every operation starts with a command write
						s_next.st = H_WRITE;
						s_next.we_n = 1'b0;
						s_next.dq_oe = 1'b1;
					end else begin
						// ident and query reads use base plus offset from the user
						s_next.st = H_READ;
						s_next.oe_n = 1'b0;
					end
				end
			end
			H_WRITE: begin
				s_next.cnt = s_reg.cnt + 8'h01;
				if (s_reg.cnt == 8'(WR_CYCLES - 1)) begin
					s_next.we_n = 1'b1; // rising we edge latches the cycle
					s_next.ce_n = 1'b1;
					s_next.st = H_GAP;
					s_next.cnt = 8'h00;
				end
			end
			H_READ: begin
				s_next.cnt = s_reg.cnt + 8'h01;
				if (s_reg.cnt == 8'(RD_CYCLES - 1)) begin
					s_next.rd_data = bus.dq;
					s_next.rd_valid = 1'b1;
					s_next.oe_n = 1'b1;
					s_next.ce_n = 1'b1;
					s_next.st = H_GAP;
					s_next.cnt = 8'h00;
				end
			end
			H_GAP: begin
				s_next.dq_oe = 1'b0;
				s_next.cnt = s_reg.cnt + 8'h01;
				if (s_reg.cnt == 8'(GAP_CYCLES - 1)) begin
					s_next.st = H_IDLE;
				end
			end
			default: s_next.st = H_IDLE;
		endcase
	end

	// state register
	always_ff @(posedge i_clk_sys) begin
		if (!i_reset_n) begin
			s_reg <= '{st: H_IDLE, ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, dev_rst_n: 1'b0,
				default: '0};
		end else begin
			s_reg <= s_next;
		end
	end

	// pins and user side
	assign bus.rst_n = s_reg.dev_rst_n;
	assign bus.ce_n = s_reg.ce_n;
	assign bus.we_n = s_reg.we_n;
	assign bus.oe_n = s_reg.oe_n;
	assign bus.addr = s_reg.addr;
	assign bus.h_dq_out = s_reg.data;
	assign bus.h_dq_oe = s_reg.dq_oe;
	assign o_cmd_ready = (s_reg.st == H_IDLE);
	assign o_rd_valid = s_reg.rd_valid;
	assign o_rd_data = s_reg.rd_data;
endmodule // fcbd_host

// File: hw/fcbd_dev.sv
`timescale 1ns/1ps
// Function
// - operations start only by command writes
// - reset aborts, suspend pauses running operation
// - 0xFF selects array read mode
// - 0x90 selects identifier read mode
// - 0x98 selects query read mode
// - 0x70 selects status, byte on low lines
// - program or erase acceptance forces status mode
// - word program: 0x40/0x10 then data
// - buffer count cycle carries words minus one
// - up to 32 words, then 0xD0 starts
// - factory buffer: 0x80, 0xD0, then stream
// - block erase: 0x20 then 0xD0
// - 0x60 then 0x01/0xD0/0x2F lock control
// - 0xC0 then data programs otp/lock register
// - 0x60, 0x03: config taken from address
// - host gives target address on first cycle
// - host reads ident/query at base plus offset
// - 0x50 clears status error flags only
// - 0xB0 suspends, status shows ready plus flag
// - 0xD0 while suspended resumes operation
// - cycle latched at first rising strobe edge
module fcbd_dev #(
	parameter int BLOCK_SHIFT = fcbd_pkg::BLOCK_SHIFT,
	parameter int PROG_CYCLES = fcbd_pkg::PROG_CYCLES,
	parameter int ERASE_CYCLES = fcbd_pkg::ERASE_CYCLES
) (
	input wire logic i_clk_sys,
	input wire logic i_reset_n,
	input wire logic i_op_fail,
	input wire logic [fcbd_pkg::DATA_W-1:0] i_array_word,
	input wire logic [fcbd_pkg::DATA_W-1:0] i_ident_word,
	input wire logic [fcbd_pkg::DATA_W-1:0] i_query_word,
	output logic [fcbd_pkg::ADDR_W-1:0] o_rd_addr,
	output fcbd_pkg::fcbd_mode_t o_rd_mode,
	output logic o_op_start,
	output fcbd_pkg::fcbd_op_t o_op_kind,
	output logic [fcbd_pkg::ADDR_W-1:0] o_op_addr,
	output logic [fcbd_pkg::DATA_W-1:0] o_op_data,
	output logic [4:0] o_buf_index,
	output logic o_busy,
	output logic o_suspended,
	output logic [15:0] o_read_config,
	fcbd_if.dev bus
);
	typedef enum logic [3:0] {
		P_NONE = 4'b0000,
		P_PROG = 4'b0001,
		P_BUF_CNT = 4'b0010,
		P_BUF_DATA = 4'b0011,
		P_BUF_CONF = 4'b0100,
		P_FAST_FACTORY_BUFFER_PROGRAM_CONF = 4'b0101,
		P_FAST_FACTORY_BUFFER_PROGRAM_STREAM = 4'b0110,
		P_ERASE = 4'b0111,
		P_LOCK = 4'b1000,
		P_OTP = 4'b1001
	} fcbd_pend_t;

	typedef struct packed {
		fcbd_pkg::fcbd_mode_t mode;
		fcbd_pend_t pend;
		logic wr_act;
		logic [fcbd_pkg::ADDR_W-1:0] cap_addr;
		logic [fcbd_pkg::DATA_W-1:0] cap_data;
		logic [fcbd_pkg::ADDR_W-1:0] tgt_addr;
		logic [5:0] buf_left;
		logic [4:0] buf_idx;
		logic busy;
		logic susp;
		logic op_erase;
		logic [fcbd_pkg::TIMER_W-1:0] timer;
		logic prog_err;
		logic erase_err;
		logic op_start;
		fcbd_pkg::fcbd_op_t op_kind;
		logic [fcbd_pkg::ADDR_W-1:0] op_addr;
		logic [fcbd_pkg::DATA_W-1:0] op_data;
		logic [15:0] cfg;
		logic [fcbd_pkg::ADDR_W-1:0] rd_addr;
		logic [fcbd_pkg::DATA_W-1:0] dq_out;
		logic dq_oe;
	} fcbd_ds_t;

	fcbd_ds_t s_reg;
	fcbd_ds_t s_next;
	logic wr_now;
	logic cmd_evt;
	logic [7:0] code;
	logic [7:0] status_byte;
	logic same_block;

	// write strobe as seen this cycle, and the end of a write cycle
	assign wr_now = ~bus.ce_n & ~bus.we_n;
	assign cmd_evt = s_reg.wr_act & ~wr_now;
	assign code = s_reg.cap_data[7:0];
	assign same_block = (s_reg.cap_addr >> BLOCK_SHIFT) == (s_reg.tgt_addr >> BLOCK_SHIFT);

	// status byte assembled from sequencer state
	always_comb begin
		status_byte = 8'h00;
		status_byte[fcbd_pkg::SR_READY] = ~s_reg.busy | s_reg.susp;
		status_byte[fcbd_pkg::SR_ERASE_SUSP] = s_reg.susp & s_reg.op_erase;
		status_byte[fcbd_pkg::SR_ERASE_ERR] = s_reg.erase_err;
		status_byte[fcbd_pkg::SR_PROG_ERR] = s_reg.prog_err;
		status_byte[fcbd_pkg::SR_PROG_SUSP] = s_reg.susp & ~s_reg.op_erase;
	end

	// command decoder, internal op sequencer and read path
	always_comb begin
		s_next = s_reg;
		s_next.op_start = 1'b0;
		s_next.wr_act = wr_now;
		if (wr_now) begin
			s_next.cap_addr = bus.addr;
			s_next.cap_data = bus.dq;
		end
		// clears first, so a flag set in the same cycle is kept
		if (cmd_evt && code == fcbd_pkg::CMD_CLEAR_STATUS && s_reg.pend == P_NONE &&
				!(s_reg.busy && !s_reg.susp)) begin
			s_next.prog_err = 1'b0;
			s_next.erase_err = 1'b0;
		end
		// sequencer counts down unless paused; it only ever sets error flags
		if (s_reg.busy && !s_reg.susp) begin
			s_next.timer = s_reg.timer - 1'b1;
			if (s_reg.timer == 1) begin
				s_next.busy = 1'b0;
				if (i_op_fail) begin
					if (s_reg.op_erase) begin
						s_next.erase_err = 1'b1;
					end else begin
						s_next.prog_err = 1'b1;
					end
				end
			end
		end
		if (cmd_evt) begin
			if (s_reg.busy && !s_reg.susp) begin
				// while running only status read and suspend are heard
				if (code == fcbd_pkg::CMD_READ_STATUS) begin
					s_next.mode = fcbd_pkg::RD_STATUS;
				end else if (code == fcbd_pkg::CMD_SUSPEND) begin
					s_next.susp = 1'b1;
					s_next.mode = fcbd_pkg::RD_STATUS;
				end
			end else begin
				case (s_reg.pend)
					P_PROG: begin
						s_next.pend = P_NONE;
						s_next.op_start = 1'b1;
						s_next.op_kind = fcbd_pkg::OP_PROG;
						s_next.op_addr = s_reg.cap_addr;
						s_next.op_data = s_reg.cap_data;
						s_next.busy = 1'b1;
						s_next.op_erase = 1'b0;
						s_next.timer = fcbd_pkg::TIMER_W'(PROG_CYCLES);
					end
					P_OTP: begin
						s_next.pend = P_NONE;
						s_next.op_start = 1'b1;
						s_next.op_kind = fcbd_pkg::OP_OTP;
						s_next.op_addr = s_reg.cap_addr;
						s_next.op_data = s_reg.cap_data;
						s_next.busy = 1'b1;
						s_next.op_erase = 1'b0;
						s_next.timer = fcbd_pkg::TIMER_W'(PROG_CYCLES);
					end
					P_BUF_CNT: begin
						if (code[7:5] == 3'b000) begin
							s_next.buf_left = {1'b0, code[4:0]} + 6'd1;
							s_next.buf_idx = 5'd0;
							s_next.pend = P_BUF_DATA;
						end else begin
							s_next.pend = P_NONE; // count beyond buffer size
							s_next.prog_err = 1'b1;
							s_next.erase_err = 1'b1;
						end
					end
					P_BUF_DATA: begin
						s_next.op_start = 1'b1; // one buffer word
						s_next.op_kind = fcbd_pkg::OP_BUF;
						s_next.op_addr = s_reg.cap_addr;
						s_next.op_data = s_reg.cap_data;
						s_next.buf_idx = s_reg.buf_idx + 5'd1;
						s_next.buf_left = s_reg.buf_left - 6'd1;
						if (s_reg.buf_left == 6'd1) begin
							s_next.pend = P_BUF_CONF;
						end
					end
					P_BUF_CONF: begin
						s_next.pend = P_NONE;
						if (code == fcbd_pkg::CMD_CONFIRM) begin
							s_next.busy = 1'b1; // only confirm starts the array write
							s_next.op_erase = 1'b0;
							s_next.timer = fcbd_pkg::TIMER_W'(PROG_CYCLES);
						end else begin
							s_next.prog_err = 1'b1;
							s_next.erase_err = 1'b1;
						end
					end
					P_FAST_FACTORY_BUFFER_PROGRAM_CONF: begin
						if (code == fcbd_pkg::CMD_CONFIRM) begin
							s_next.pend = P_FAST_FACTORY_BUFFER_PROGRAM_STREAM;
							s_next.tgt_addr = s_reg.cap_addr;
							s_next.buf_idx = 5'd0;
						end else begin
							s_next.pend = P_NONE;
							s_next.prog_err = 1'b1;
							s_next.erase_err = 1'b1;
						end
					end
					P_FAST_FACTORY_BUFFER_PROGRAM_STREAM: begin
						if (same_block) begin
							s_next.op_start = 1'b1; // streamed word
							s_next.op_kind = fcbd_pkg::OP_FAST_FACTORY_BUFFER_PROGRAM_WORD;
							s_next.op_addr = s_reg.cap_addr;
							s_next.op_data = s_reg.cap_data;
							s_next.buf_idx = s_reg.buf_idx + 5'd1;
						end else begin
							s_next.pend = P_NONE; // write outside the block ends streaming
						end
					end
					P_ERASE: begin
						s_next.pend = P_NONE;
						if (code == fcbd_pkg::CMD_CONFIRM) begin
							s_next.op_start = 1'b1;
							s_next.op_kind = fcbd_pkg::OP_ERASE;
							s_next.op_addr = s_reg.cap_addr;
							s_next.busy = 1'b1;
							s_next.op_erase = 1'b1;
							s_next.timer = fcbd_pkg::TIMER_W'(ERASE_CYCLES);
						end else begin
							s_next.prog_err = 1'b1; // bad erase sequence
							s_next.erase_err = 1'b1;
						end
					end
					P_LOCK: begin
						s_next.pend = P_NONE;
						s_next.op_addr = s_reg.cap_addr;
						s_next.op_start = 1'b1;
						if (code == fcbd_pkg::CMD_LOCK) begin
							s_next.op_kind = fcbd_pkg::OP_LOCK;
						end else if (code == fcbd_pkg::CMD_CONFIRM) begin
							s_next.op_kind = fcbd_pkg::OP_UNLOCK;
						end else if (code == fcbd_pkg::CMD_LOCKDOWN) begin
							s_next.op_kind = fcbd_pkg::OP_LOCKDOWN;
						end else if (code == fcbd_pkg::CMD_CFG) begin
							s_next.op_kind = fcbd_pkg::OP_CFG;
							s_next.cfg = s_reg.cap_addr[15:0]; // value on address lines
						end else begin
							s_next.op_start = 1'b0;
							s_next.prog_err = 1'b1;
							s_next.erase_err = 1'b1;
						end
					end
					default: begin
						// single-cycle commands and first cycles
						s_next.tgt_addr = s_reg.cap_addr;
						if (code == fcbd_pkg::CMD_READ_ARRAY) begin
							s_next.mode = fcbd_pkg::RD_ARRAY;
						end else if (code == fcbd_pkg::CMD_READ_IDENT) begin
							s_next.mode = fcbd_pkg::RD_IDENT;
						end else if (code == fcbd_pkg::CMD_READ_QUERY) begin
							s_next.mode = fcbd_pkg::RD_QUERY;
						end else if (code == fcbd_pkg::CMD_READ_STATUS) begin
							s_next.mode = fcbd_pkg::RD_STATUS;
						end else if (code == fcbd_pkg::CMD_CONFIRM && s_reg.susp) begin
							s_next.susp = 1'b0;
							s_next.mode = fcbd_pkg::RD_STATUS;
						end else if (s_reg.susp) begin
							s_next.pend = P_NONE; // no new operation while paused
						end else if (code == fcbd_pkg::CMD_PROG_SETUP ||
								code == fcbd_pkg::CMD_PROG_SETUP_ALT) begin
							s_next.pend = P_PROG;
						end else if (code == fcbd_pkg::CMD_BUF_PROG) begin
							s_next.pend = P_BUF_CNT;
						end else if (code == fcbd_pkg::CMD_FAST_FACTORY_BUFFER_PROGRAM_SETUP) begin
							s_next.pend = P_FAST_FACTORY_BUFFER_PROGRAM_CONF;
						end else if (code == fcbd_pkg::CMD_ERASE_SETUP) begin
							s_next.pend = P_ERASE;
						end else if (code == fcbd_pkg::CMD_LOCK_SETUP) begin
							s_next.pend = P_LOCK;
						end else if (code == fcbd_pkg::CMD_OTP_SETUP) begin
							s_next.pend = P_OTP;
						end
					end
				endcase
				// program/erase sequences switch reads to status on their own
				if (s_next.pend != P_NONE && s_next.pend != P_LOCK) begin
					s_next.mode = fcbd_pkg::RD_STATUS;
				end
				if (s_next.prog_err && !s_reg.prog_err) begin
					s_next.mode = fcbd_pkg::RD_STATUS;
				end
			end
		end
		// registered read data for the selected mode
		s_next.rd_addr = bus.addr;
		s_next.dq_oe = ~bus.ce_n & ~bus.oe_n & bus.we_n;
		case (s_reg.mode)
			fcbd_pkg::RD_STATUS: s_next.dq_out = {8'h00, status_byte};
			fcbd_pkg::RD_IDENT: s_next.dq_out = i_ident_word;
			fcbd_pkg::RD_QUERY: s_next.dq_out = i_query_word;
			default: s_next.dq_out = i_array_word;
		endcase
	end

	// state register; the device reset pin aborts like the system reset
	always_ff @(posedge i_clk_sys) begin
		if (!i_reset_n || !bus.rst_n) begin
			s_reg <= '{mode: fcbd_pkg::RD_ARRAY, pend: P_NONE, op_kind: fcbd_pkg::OP_NONE,
				cfg: fcbd_pkg::CFG_RESET, default: '0};
		end else begin
			s_reg <= s_next;
		end
	end

	// outputs
	assign bus.d_dq_out = s_reg.dq_out;
	assign bus.d_dq_oe = s_reg.dq_oe;
	assign o_rd_addr = s_reg.rd_addr;
	assign o_rd_mode = s_reg.mode;
	assign o_op_start = s_reg.op_start;
	assign o_op_kind = s_reg.op_kind;
	assign o_op_addr = s_reg.op_addr;
	assign o_op_data = s_reg.op_data;
	assign o_buf_index = s_reg.buf_idx;
	assign o_busy = s_reg.busy;
	assign o_suspended = s_reg.susp;
	assign o_read_config = s_reg.cfg;
endmodule // fcbd_dev

// File: tb/fcbd_monitor.sv
`timescale 1ns/1ps
// watches the shared flash command bus between host and device ends
module fcbd_monitor #(parameter int ADDR_W = 24, parameter int DATA_W = 16) (
	input wire logic i_clk_sys,
	input wire logic i_reset_n,
	input wire logic i_rst_n,
	input wire logic i_ce_n,
	input wire logic i_we_n,
	input wire logic i_oe_n,
	input wire logic [ADDR_W-1:0] i_addr,
	input wire logic [DATA_W-1:0] i_h_dq_out,
	input wire logic i_h_dq_oe,
	input wire logic [DATA_W-1:0] i_d_dq_out,
	input wire logic i_d_dq_oe,
	input wire logic [DATA_W-1:0] i_dq
);
	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (!i_reset_n || !i_rst_n);

	// write strobe: two selected low cycles, then released
	sequence s_wr;
		(!i_we_n && !i_ce_n)[*2] ##1 i_we_n;
	endsequence
	// read window: four selected low cycles of output enable
	sequence s_rd;
		(!i_oe_n && !i_ce_n)[*4] ##1 i_oe_n;
	endsequence

	property p_wr_strobe;
		$fell(i_we_n) |-> s_wr;
	endproperty
	a_wr_strobe: assert property (p_wr_strobe) else $error("write strobe length wrong");
	property p_wr_hold;
		(!i_we_n && $past(!i_we_n)) |-> i_h_dq_oe && $stable(i_addr) && $stable(i_h_dq_out);
	endproperty
	a_wr_hold: assert property (p_wr_hold) else $error("write cycle moved");
	property p_wr_after;
		$rose(i_we_n) |-> i_h_dq_oe && $stable(i_h_dq_out);
	endproperty
	a_wr_after: assert property (p_wr_after) else $error("data dropped at strobe");
	property p_we_oe;
		!(!i_we_n && !i_oe_n);
	endproperty
	a_we_oe: assert property (p_we_oe) else $error("read and write overlap");
	property p_rd_window;
		$fell(i_oe_n) |-> s_rd;
	endproperty
	a_rd_window: assert property (p_rd_window) else $error("read window wrong");
	property p_rd_drive;
		$fell(i_oe_n) |-> ##3 (i_d_dq_oe && i_dq == i_d_dq_out);
	endproperty
	a_rd_drive: assert property (p_rd_drive) else $error("device silent on read");
	property p_drive_only_read;
		i_d_dq_oe |-> !i_oe_n || !$past(i_oe_n) || !$past(i_oe_n, 2);
	endproperty
	a_drive_only_read: assert property (p_drive_only_read) else $error("stray drive");
	property p_no_clash;
		!(i_d_dq_oe && i_h_dq_oe);
	endproperty
	a_no_clash: assert property (p_no_clash) else $error("bus contention");
	property p_reset_quiet;
		disable iff (!i_reset_n) !i_rst_n |=> !i_d_dq_oe;
	endproperty
	a_reset_quiet: assert property (p_reset_quiet) else $error("drive in reset");
endmodule // fcbd_monitor

// File: tb/tb.sv
`timescale 1ns/1ps
module tb;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic dev_reset = 1'b0;
	logic cmd_valid = 1'b0;
	logic cmd_write = 1'b0;
	logic [23:0] cmd_addr = 24'h000000;
	logic [15:0] cmd_data = 16'h0000;
	logic op_fail = 1'b0;
	logic cmd_ready, rd_valid, op_start, busy, susp;
	logic [15:0] rd_data, op_data, rcfg;
	logic [23:0] rd_addr, op_addr;
	logic [4:0] buf_index;
	fcbd_pkg::fcbd_mode_t rd_mode;
	fcbd_pkg::fcbd_op_t op_kind;
	int fail_count = 0;
	int n_tests = 0;
	int md = 0;
	logic [7:0] st = 8'h80;
	logic [48:0] exp_q[$];
	logic [48:0] got_q[$];

	fcbd_if bif();
	fcbd_host fcbd_host_i (.i_clk_sys(clk), .i_reset_n(reset_n), .i_dev_reset(dev_reset),
		.i_cmd_valid(cmd_valid), .i_cmd_write(cmd_write), .i_cmd_addr(cmd_addr),
		.i_cmd_data(cmd_data), .o_cmd_ready(cmd_ready), .o_rd_valid(rd_valid),
		.o_rd_data(rd_data), .bus(bif.host));
	// user words are simple functions of the read address
	fcbd_dev #(.PROG_CYCLES(8), .ERASE_CYCLES(40)) fcbd_dev_i (.i_clk_sys(clk),
		.i_reset_n(reset_n), .i_op_fail(op_fail), .i_array_word(rd_addr[15:0] ^ 16'h1234),
		.i_ident_word(rd_addr[15:0] ^ 16'h5A5A), .i_query_word(rd_addr[15:0] ^ 16'h0F0F),
		.o_rd_addr(rd_addr), .o_rd_mode(rd_mode), .o_op_start(op_start), .o_op_kind(op_kind),
		.o_op_addr(op_addr), .o_op_data(op_data), .o_buf_index(buf_index), .o_busy(busy),
		.o_suspended(susp), .o_read_config(rcfg), .bus(bif.dev));
	fcbd_monitor fcbd_monitor_i (.i_clk_sys(clk), .i_reset_n(reset_n), .i_rst_n(bif.rst_n),
		.i_ce_n(bif.ce_n), .i_we_n(bif.we_n), .i_oe_n(bif.oe_n), .i_addr(bif.addr),
		.i_h_dq_out(bif.h_dq_out), .i_h_dq_oe(bif.h_dq_oe), .i_d_dq_out(bif.d_dq_out),
		.i_d_dq_oe(bif.d_dq_oe), .i_dq(bif.dq));

	// operation record, data and index kept only where they matter
	function automatic logic [48:0] op_rec(input logic [3:0] k, input logic [23:0] a,
		input logic [15:0] d, input logic [4:0] i);
		return {k, a, (k inside {4'h1, 4'h2, 4'h3, 4'h8}) ? d : 16'h0000,
			(k inside {4'h2, 4'h3}) ? i : 5'h00};
	endfunction
	// model read word for the current mode
	function automatic logic [15:0] exp_rd(input logic [23:0] a);
		case (md)
			0: return a[15:0] ^ 16'h1234;
			1: return a[15:0] ^ 16'h5A5A;
			2: return a[15:0] ^ 16'h0F0F;
			default: return {8'h00, st};
		endcase
	endfunction
	task automatic chk(input string nm, input logic [48:0] e, input logic [48:0] g);
		n_tests++;
		if (g !== e) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	// one host request, entered and left just after a rising edge
	task automatic req(input logic w, input logic [23:0] a, input logic [15:0] d);
		int n;
		n = 0;
		while (cmd_ready !== 1'b1 && n < 50) begin
			@(posedge clk);
			#1;
			n++;
		end
		chk("cmd ready", 49'h1, 49'(cmd_ready));
		cmd_valid = 1'b1;
		cmd_write = w;
		cmd_addr = a;
		cmd_data = d;
		@(posedge clk);
		#1;
		cmd_valid = 1'b0;
	endtask
	task automatic wr(input logic [23:0] a, input logic [15:0] d);
		req(1'b1, a, d);
	endtask
	task automatic rd(input logic [23:0] a);
		logic [15:0] m;
		int n;
		m = (md == 3) ? 16'h00FF : 16'hFFFF;
		req(1'b0, a, 16'h0000);
		n = 0;
		while (rd_valid !== 1'b1 && n < 20) begin
			@(posedge clk);
			#1;
			n++;
		end
		chk("read valid", 49'h1, 49'(rd_valid));
		chk("read data", 49'(exp_rd(a) & m), 49'(rd_data & m));
		chk("read mode", 49'(md), 49'(rd_mode));
	endtask
	task automatic wait_idle();
		int n;
		n = 0;
		repeat (5) @(posedge clk);
		#1;
		while (busy !== 1'b0 && n < 300) begin
			@(posedge clk);
			#1;
			n++;
		end
		chk("busy", 49'h0, 49'(busy));
	endtask
	task automatic done(input string nm);
		chk("op count", 49'(exp_q.size()), 49'(got_q.size()));
		while (exp_q.size() > 0 && got_q.size() > 0) begin
			chk("op record", exp_q.pop_front(), got_q.pop_front());
		end
		exp_q.delete();
		got_q.delete();
		$display("test %s finished", nm);
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// clock
	initial begin
		forever #20 clk = ~clk;
	end
	// watchdog cuts a hang short
	initial begin
		#(40 * 30000);
		fail_count++;
		$display("[FAIL] watchdog expected end seen hang");
		end_sim();
	end
	// collect every operation pulse
	always @(posedge clk) begin
		if (op_start === 1'b1) begin
			got_q.push_back(op_rec(op_kind, op_addr, op_data, buf_index));
		end
	end

	// main sequence
	initial begin
		logic [23:0] a;
		logic [15:0] d;
		int n;
		logic [7:0] rc[4];
		logic [7:0] lk[3];
		rc = '{8'hFF, 8'h90, 8'h98, 8'h70};
		lk = '{8'h01, 8'hD0, 8'h2F};
		a = 24'($urandom(49211));
		repeat (3) @(posedge clk);
		#1;
		reset_n = 1'b1;
		for (int i = 0; i < 4; i++) begin
			wr(24'($urandom), {8'($urandom), rc[i]});
			md = i;
			rd(24'($urandom % 256));
		end
		done("read modes");
		for (int i = 0; i < 2; i++) begin
			a = 24'($urandom);
			d = 16'($urandom);
			op_fail = 1'(i);
			wr(a, (i == 0) ? 16'h0040 : 16'h0010);
			wr(a, d);
			exp_q.push_back(op_rec(4'h1, a, d, 5'h00));
			md = 3;
			st = 8'h00;
			rd(a);
			wait_idle();
			st = (i == 0) ? 8'h80 : 8'h90;
			rd(a);
		end
		op_fail = 1'b0;
		wr(a, 16'h0050);
		st = 8'h80;
		rd(a);
		done("word program");
		a = 24'($urandom);
		wr(a, 16'h0020);
		wr(a, 16'h00D0);
		exp_q.push_back(op_rec(4'h4, a, 16'h0000, 5'h00));
		wr(a, 16'h00FF);
		st = 8'h00;
		rd(a);
		wr(a ^ 24'h00F0F0, 16'h00B0);
		st = 8'hC0;
		rd(a);
		chk("suspended", 49'h1, 49'(susp));
		wr(24'($urandom), 16'h00D0);
		st = 8'h00;
		rd(a);
		wait_idle();
		wr(a, 16'h0020);
		wr(a, 16'h0055);
		st = 8'hB0;
		rd(a);
		wr(a, 16'h0050);
		st = 8'h80;
		rd(a);
		done("erase and suspend");
		for (int i = 0; i < 3; i++) begin
			a = 24'($urandom);
			wr(a, 16'h0060);
			wr(a, {8'h00, lk[i]});
			exp_q.push_back(op_rec(4'(5 + i), a, 16'h0000, 5'h00));
			wait_idle();
		end
		a = 24'($urandom);
		wr(a, 16'h0060);
		wr(a, 16'h0003);
		exp_q.push_back(op_rec(4'h9, a, 16'h0000, 5'h00));
		wait_idle();
		chk("config", 49'(a[15:0]), 49'(rcfg));
		d = 16'($urandom);
		wr(a, 16'h00C0);
		wr(a, d);
		exp_q.push_back(op_rec(4'h8, a, d, 5'h00));
		wait_idle();
		wr(a, 16'h00FF);
		md = 0;
		rd(a);
		done("lock and registers");
		for (int j = 0; j < 2; j++) begin
			n = (j == 0) ? 32 : 1 + $urandom % 31;
			a = 24'($urandom);
			wr(a, 16'h00E8);
			wr(a, 16'(n - 1));
			for (int i = 0; i < n; i++) begin
				d = 16'($urandom);
				wr(a + 24'(i), d);
				exp_q.push_back(op_rec(4'h2, a + 24'(i), d, 5'(i + 1)));
			end
			wr(a, 16'h00D0);
			md = 3;
			st = 8'h00;
			rd(a);
			wait_idle();
		end
		done("buffered program");
		a = {8'($urandom % 200), 16'h0000};
		wr(a, 16'h0080);
		wr(a, 16'h00D0);
		for (int i = 0; i < 6; i++) begin
			d = 16'($urandom);
			wr(a + 24'(i), d);
			exp_q.push_back(op_rec(4'h3, a + 24'(i), d, 5'(i + 1)));
		end
		wr(a + 24'h010000, 16'h00FF);
		wait_idle();
		wr(a, 16'h00FF);
		md = 0;
		rd(a);
		done("factory stream");
		a = 24'($urandom);
		wr(a, 16'h0020);
		wr(a, 16'h00D0);
		exp_q.push_back(op_rec(4'h4, a, 16'h0000, 5'h00));
		// let the confirm cycle finish before the reset pin aborts the erase
		repeat (4) @(posedge clk);
		#1;
		chk("busy before reset", 49'h1, 49'(busy));
		dev_reset = 1'b1;
		repeat (3) @(posedge clk);
		#1;
		dev_reset = 1'b0;
		repeat (2) @(posedge clk);
		#1;
		chk("busy after reset", 49'h0, 49'(busy));
		md = 0;
		rd(a);
		wr(a, 16'h0070);
		md = 3;
		st = 8'h80;
		rd(a);
		done("reset abort");
		end_sim();
	end
endmodule // tb
